/* rtl/otgsc_top.sv */
// Added by the designer: the strobed register port.
`timescale 1ns/100ps
// Functional notes
// - Bit 0 read-only: session request outcome, 1 success, 0 failure.
// - Bit 1 read/write: software writes 1 to request a session.
// - Session request bit auto-clears when negotiation-change flag is cleared.
// - Bit 8 read-only negotiation outcome, cleared when negotiation request is set.
// - Bit 9 requests negotiation; auto-clears when negotiation-change flag clears.
// - Bit 16 shows connector identity: 0 A-device, 1 B-device.
// - Bit 17 shows detected debounce: 0 long, 1 short.
// - Bit 18 shows A-session valid.
// - Bit 19 shows B-session valid.
// - Control state reads 0x0000_0800 after reset.
// - Global words decode 0x00..0x3C except 0x34, and 0x100..0x10C.
// - Negotiation-change flag sets when negotiation outcome changes; write 1 clears.
module otgsc_top
  import otgsc_pkg::*;
#(
  parameter logic [31:0] CORE_ID = 32'h0000_5A01 // Arbitrary identity value
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_B_I,
  // Register port
  input wire otgsc_bus_t BUS_I,
  output logic [31:0] RDATA_O,
  // Transceiver status and protocol events
  input wire otgsc_line_t LINE_I,
  input wire otgsc_evt_t EVT_I,
  // Requests towards the protocol engine
  output logic SESSION_REQUEST_O,
  output logic NEGOTIATION_REQUEST_O,
  output logic HOST_NEG_ENABLE_O,
  output logic DEV_NEG_ENABLE_O,
  // Interrupt
  output logic IRQ_O
);

  //////////////////////////////////////////////////////////////////////////////
  // Address decode

  // Map an offset onto a storage word, or none
  function automatic logic [3:0] store_index(input logic [11:0] addr);
    logic [3:0] idx;
    idx = STORE_NONE;
    case (addr)
      OFS_BUS_SIDE_CFG: idx = 4'h0;
      OFS_USB_SIDE_CFG: idx = 4'h1;
      OFS_RESET_CONTROL: idx = 4'h2;
      OFS_CORE_INT_STATUS: idx = 4'h3;
      OFS_CORE_INT_MASK: idx = 4'h4;
      OFS_RX_FIFO_SIZE: idx = 4'h5;
      OFS_TX_FIFO_CFG: idx = 4'h6;
      OFS_GENERAL_CFG: idx = 4'h7;
      OFS_HOST_PER_FIFO: idx = 4'h8;
      OFS_IN_EP_FIFO_1: idx = 4'h9;
      OFS_IN_EP_FIFO_2: idx = 4'hA;
      OFS_IN_EP_FIFO_3: idx = 4'hB;
      default: idx = STORE_NONE;
    endcase
    return idx;
  endfunction : store_index

  // Strobe qualification per register
  wire logic [3:0] wr_idx = store_index(BUS_I.addr);
  wire logic [3:0] rd_idx = store_index(BUS_I.addr);
  wire logic wr_ctrl = BUS_I.wr && (BUS_I.addr == OFS_CONTROL_STATE);
  wire logic wr_flags = BUS_I.wr && (BUS_I.addr == OFS_EVENT_FLAGS);
  wire logic wr_mask = BUS_I.wr && (BUS_I.addr == OFS_EVENT_MASK);

  //////////////////////////////////////////////////////////////////////////////
  // Plain storage words

  logic [31:0] store_ff [STORE_WORDS];

  // One word per generate pass; no side effects beyond storing
  generate
    for (genvar g = 0; g < STORE_WORDS; g++) begin : g_store
      always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
          store_ff[g] <= STORE_RESET;
        end else if (BUS_I.wr && (wr_idx == 4'(g))) begin
          store_ff[g] <= BUS_I.wdata;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // Line status capture

  logic [3:0] line_ff;
  logic b_valid_prev_ff;

  // Inputs are synchronous; a register keeps the read stable
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      line_ff <= 4'h0;
      b_valid_prev_ff <= 1'b0;
    end else begin
      line_ff <= LINE_I;
      b_valid_prev_ff <= line_ff[3];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Control state bits

  logic session_request_ok_ff;
  logic session_request_ff;
  logic negotiation_ok_ff;
  logic negotiation_request_ff;
  logic host_neg_enable_ff;
  logic dev_neg_enable_ff;
  logic [31:0] flags_ff;
  logic [31:0] mask_ff;

  // Negotiation-change flag leaving the set state
  wire logic [31:0] flag_clear = wr_flags ? (BUS_I.wdata & FLAG_MASK) : 32'h0000_0000;
  logic [31:0] flag_set;
  wire logic [31:0] nxt_flags = ((flags_ff & ~flag_clear) | flag_set) & FLAG_MASK;
  wire logic nego_flag_dropped = flags_ff[FLG_NEGOTIATION_OK_CHG] &&
                                 !nxt_flags[FLG_NEGOTIATION_OK_CHG];

  // Outcome bits follow the engine's result pulses
  wire logic nxt_session_request_ok = EVT_I.srp_done ? EVT_I.srp_ok : session_request_ok_ff;
  // A result in the same cycle as a request write wins over the clear
  wire logic nego_req_written = wr_ctrl && BUS_I.wdata[BIT_NEGOTIATION_REQUEST];
  wire logic nxt_negotiation_ok = EVT_I.hnp_done ? EVT_I.hnp_ok :
                                  nego_req_written ? 1'b0 : negotiation_ok_ff;

  // Requests: software write, else auto-clear on flag clear
  wire logic nxt_session_request = wr_ctrl ? BUS_I.wdata[BIT_SESSION_REQUEST] :
                                   nego_flag_dropped ? 1'b0 : session_request_ff;
  wire logic nxt_negotiation_request = wr_ctrl ? BUS_I.wdata[BIT_NEGOTIATION_REQUEST] :
                                       nego_flag_dropped ? 1'b0 :
                                       negotiation_request_ff;
  wire logic nxt_host_neg_enable = wr_ctrl ? BUS_I.wdata[BIT_HOST_NEG_ENABLE] :
                                   host_neg_enable_ff;
  wire logic nxt_dev_neg_enable = wr_ctrl ? BUS_I.wdata[BIT_DEV_NEG_ENABLE] :
                                  dev_neg_enable_ff;

  // Control state register; reserved bits are simply not stored
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      session_request_ok_ff <= CTRL_RESET[BIT_SESSION_REQUEST_OK];
      session_request_ff <= CTRL_RESET[BIT_SESSION_REQUEST];
      negotiation_ok_ff <= CTRL_RESET[BIT_NEGOTIATION_OK];
      negotiation_request_ff <= CTRL_RESET[BIT_NEGOTIATION_REQUEST];
      host_neg_enable_ff <= CTRL_RESET[BIT_HOST_NEG_ENABLE];
      dev_neg_enable_ff <= CTRL_RESET[BIT_DEV_NEG_ENABLE];
    end else begin
      session_request_ok_ff <= nxt_session_request_ok;
      session_request_ff <= nxt_session_request;
      negotiation_ok_ff <= nxt_negotiation_ok;
      negotiation_request_ff <= nxt_negotiation_request;
      host_neg_enable_ff <= nxt_host_neg_enable;
      dev_neg_enable_ff <= nxt_dev_neg_enable;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Event flags, mask and interrupt

  // Hardware set sources; a set in the clearing cycle survives
  always_comb begin
    flag_set = 32'h0000_0000;
    flag_set[FLG_SESSION_END] = b_valid_prev_ff && !line_ff[3];
    flag_set[FLG_SESSION_OK_CHG] = nxt_session_request_ok != session_request_ok_ff;
    flag_set[FLG_NEGOTIATION_OK_CHG] = nxt_negotiation_ok != negotiation_ok_ff;
    flag_set[FLG_NEGOTIATION_SEEN] = EVT_I.hnp_seen;
    flag_set[FLG_A_TIMEOUT] = EVT_I.a_timeout;
    flag_set[FLG_DEBOUNCE_DONE] = EVT_I.debounce_done;
  end

  wire logic [31:0] nxt_mask = wr_mask ? (BUS_I.wdata & FLAG_MASK) : mask_ff;
  wire logic nxt_irq = |(nxt_flags & nxt_mask);

  // Flags, mask and the registered interrupt level
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      flags_ff <= FLAG_RESET;
      mask_ff <= FLAG_RESET;
      IRQ_O <= 1'b0;
    end else begin
      flags_ff <= nxt_flags;
      mask_ff <= nxt_mask;
      IRQ_O <= nxt_irq;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read path

  // Assembled control word; unused positions are constant zero
  wire logic [31:0] ctrl_word = {12'h000, line_ff, 4'h0, dev_neg_enable_ff,
                                 host_neg_enable_ff, negotiation_request_ff,
                                 negotiation_ok_ff, 6'h00, session_request_ff,
                                 session_request_ok_ff};
  wire logic [31:0] store_word = (rd_idx == STORE_NONE) ? 32'h0000_0000 : store_ff[rd_idx];

  // Status, flags, mask, identity or storage; unmapped and read-only queues read zero
  wire logic [31:0] rd_mux = (BUS_I.addr == OFS_CONTROL_STATE) ? ctrl_word :
                             (BUS_I.addr == OFS_EVENT_FLAGS) ? flags_ff :
                             (BUS_I.addr == OFS_EVENT_MASK) ? mask_ff :
                             (BUS_I.addr == OFS_CORE_IDENTITY) ? CORE_ID :
                             store_word;
  wire logic [31:0] nxt_rdata = BUS_I.rd ? rd_mux : 32'h0000_0000;

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RDATA_O <= 32'h0000_0000;
      SESSION_REQUEST_O <= CTRL_RESET[BIT_SESSION_REQUEST];
      NEGOTIATION_REQUEST_O <= CTRL_RESET[BIT_NEGOTIATION_REQUEST];
      HOST_NEG_ENABLE_O <= CTRL_RESET[BIT_HOST_NEG_ENABLE];
      DEV_NEG_ENABLE_O <= CTRL_RESET[BIT_DEV_NEG_ENABLE];
    end else begin
      RDATA_O <= nxt_rdata;
      SESSION_REQUEST_O <= nxt_session_request;
      NEGOTIATION_REQUEST_O <= nxt_negotiation_request;
      HOST_NEG_ENABLE_O <= nxt_host_neg_enable;
      DEV_NEG_ENABLE_O <= nxt_dev_neg_enable;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  // First cycle after reset release
  logic first_ff;
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      first_ff <= 1'b1;
    end else begin
      first_ff <= 1'b0;
    end
  end

  sequence s_read_ctrl;
    BUS_I.rd && (BUS_I.addr == OFS_CONTROL_STATE);
  endsequence

  sequence s_nego_flag_drop;
    flags_ff[FLG_NEGOTIATION_OK_CHG] ##1 !flags_ff[FLG_NEGOTIATION_OK_CHG];
  endsequence

  property p_srp_outcome;
    @(posedge CLK_I) disable iff (!RST_B_I)
      EVT_I.srp_done |=> (session_request_ok_ff == $past(EVT_I.srp_ok));
  endproperty
  a_srp_outcome: assert property (p_srp_outcome)
    else $error("session request outcome not captured");

  property p_session_request_write;
    @(posedge CLK_I) disable iff (!RST_B_I)
      wr_ctrl |=> (SESSION_REQUEST_O == $past(BUS_I.wdata[BIT_SESSION_REQUEST]));
  endproperty
  a_session_request_write: assert property (p_session_request_write)
    else $error("session request does not follow write");

  property p_session_request_auto_clear;
    @(posedge CLK_I) disable iff (!RST_B_I)
      (s_nego_flag_drop and (!wr_ctrl ##1 1'b1)) |-> !session_request_ff;
  endproperty
  a_session_request_auto_clear: assert property (p_session_request_auto_clear)
    else $error("session request kept after flag clear");

  property p_negotiation_ok_clear;
    @(posedge CLK_I) disable iff (!RST_B_I)
      (nego_req_written && !EVT_I.hnp_done) |=> !negotiation_ok_ff;
  endproperty
  a_negotiation_ok_clear: assert property (p_negotiation_ok_clear)
    else $error("negotiation outcome not cleared by request");

  property p_negotiation_request_auto_clear;
    @(posedge CLK_I) disable iff (!RST_B_I)
      (s_nego_flag_drop and (!wr_ctrl ##1 1'b1)) |-> !NEGOTIATION_REQUEST_O;
  endproperty
  a_negotiation_request_auto_clear: assert property (p_negotiation_request_auto_clear)
    else $error("negotiation request kept after flag clear");

  property p_identity_debounce_read;
    @(posedge CLK_I) disable iff (!RST_B_I)
      s_read_ctrl |=> (RDATA_O[BIT_DEBOUNCE_LEN:BIT_CONNECTOR_ID] == $past(line_ff[1:0]));
  endproperty
  a_identity_debounce_read: assert property (p_identity_debounce_read)
    else $error("identity or debounce status misread");

  property p_session_valid_read;
    @(posedge CLK_I) disable iff (!RST_B_I)
      s_read_ctrl ##1 1'b1 |-> (RDATA_O[BIT_B_SESSION_VALID:BIT_A_SESSION_VALID] ==
                                $past(LINE_I[3:2], 2));
  endproperty
  a_session_valid_read: assert property (p_session_valid_read)
    else $error("session valid status misread");

  property p_reset_value;
    @(posedge CLK_I) disable iff (!RST_B_I)
      first_ff |-> ((ctrl_word & 32'h0000_0F03) == CTRL_RESET);
  endproperty
  a_reset_value: assert property (p_reset_value)
    else $error("control state reset value wrong");

  property p_unmapped_zero;
    @(posedge CLK_I) disable iff (!RST_B_I)
      (BUS_I.rd && (BUS_I.addr > OFS_IN_EP_FIFO_3)) |=> (RDATA_O == 32'h0000_0000);
  endproperty
  a_unmapped_zero: assert property (p_unmapped_zero)
    else $error("unmapped read not zero");

  property p_change_sets_flag;
    @(posedge CLK_I) disable iff (!RST_B_I)
      (negotiation_ok_ff != $past(negotiation_ok_ff)) |-> flags_ff[FLG_NEGOTIATION_OK_CHG];
  endproperty
  a_change_sets_flag: assert property (p_change_sets_flag)
    else $error("negotiation change flag not set");

  property p_reserved_zero;
    @(posedge CLK_I) disable iff (!RST_B_I)
      s_read_ctrl |=> ((RDATA_O & ~CTRL_READ_MASK) == 32'h0000_0000);
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved control bits not zero");

  property p_irq_level;
    @(posedge CLK_I) disable iff (!RST_B_I)
      IRQ_O == |(flags_ff & mask_ff);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level disagrees with flags");

  // Negotiation request output follows the software write
  property p_negotiation_request_write;
    @(posedge CLK_I) disable iff (!RST_B_I)
      wr_ctrl |=> (NEGOTIATION_REQUEST_O == $past(BUS_I.wdata[BIT_NEGOTIATION_REQUEST]));
  endproperty
  a_negotiation_request_write: assert property (p_negotiation_request_write)
    else $error("negotiation request does not follow write");

  // Software writes never move the session outcome; only a result pulse does
  property p_outcome_read_only;
    @(posedge CLK_I) disable iff (!RST_B_I)
      (wr_ctrl && !EVT_I.srp_done) |=>
        (session_request_ok_ff == $past(session_request_ok_ff));
  endproperty
  a_outcome_read_only: assert property (p_outcome_read_only)
    else $error("session outcome moved by a write");

  // Line levels land one cycle after they are presented
  property p_line_capture;
    @(posedge CLK_I) disable iff (!RST_B_I)
      !first_ff |-> (line_ff == $past(LINE_I));
  endproperty
  a_line_capture: assert property (p_line_capture)
    else $error("line status not captured");

  // Loss of B-session validity raises the session end flag
  property p_session_end_flag;
    @(posedge CLK_I) disable iff (!RST_B_I)
      $fell(line_ff[3]) |=> flags_ff[FLG_SESSION_END];
  endproperty
  a_session_end_flag: assert property (p_session_end_flag)
    else $error("session end flag not set");

  // Any move of the session outcome raises its change flag
  property p_session_change_flag;
    @(posedge CLK_I) disable iff (!RST_B_I)
      (session_request_ok_ff != $past(session_request_ok_ff)) |->
        flags_ff[FLG_SESSION_OK_CHG];
  endproperty
  a_session_change_flag: assert property (p_session_change_flag)
    else $error("session change flag not set");

  // Read data stand only in the cycle after a read strobe
  property p_rdata_idle;
    @(posedge CLK_I) disable iff (!RST_B_I)
      !BUS_I.rd |=> (RDATA_O == 32'h0000_0000);
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not idle");

endmodule : otgsc_top

/* inc/otgsc_pkg.sv */
package otgsc_pkg;

  // Register offsets (byte addresses)
  localparam logic [11:0] OFS_CONTROL_STATE = 12'h000;
  localparam logic [11:0] OFS_EVENT_FLAGS = 12'h004;
  localparam logic [11:0] OFS_BUS_SIDE_CFG = 12'h008;
  localparam logic [11:0] OFS_USB_SIDE_CFG = 12'h00C;
  localparam logic [11:0] OFS_RESET_CONTROL = 12'h010;
  localparam logic [11:0] OFS_CORE_INT_STATUS = 12'h014;
  localparam logic [11:0] OFS_CORE_INT_MASK = 12'h018;
  localparam logic [11:0] OFS_RX_STATUS_PEEK = 12'h01C;
  localparam logic [11:0] OFS_RX_STATUS_POP = 12'h020;
  localparam logic [11:0] OFS_RX_FIFO_SIZE = 12'h024;
  localparam logic [11:0] OFS_TX_FIFO_CFG = 12'h028;
  localparam logic [11:0] OFS_NP_QUEUE_STATE = 12'h02C;
  localparam logic [11:0] OFS_EVENT_MASK = 12'h030;
  localparam logic [11:0] OFS_GENERAL_CFG = 12'h038;
  localparam logic [11:0] OFS_CORE_IDENTITY = 12'h03C;
  localparam logic [11:0] OFS_HOST_PER_FIFO = 12'h100;
  localparam logic [11:0] OFS_IN_EP_FIFO_1 = 12'h104;
  localparam logic [11:0] OFS_IN_EP_FIFO_2 = 12'h108;
  localparam logic [11:0] OFS_IN_EP_FIFO_3 = 12'h10C;

  // Plain storage words
  localparam int unsigned STORE_WORDS = 12;
  localparam logic [3:0] STORE_NONE = 4'hF;

  // Control state field positions
  localparam int unsigned BIT_SESSION_REQUEST_OK = 0;
  localparam int unsigned BIT_SESSION_REQUEST = 1;
  localparam int unsigned BIT_NEGOTIATION_OK = 8;
  localparam int unsigned BIT_NEGOTIATION_REQUEST = 9;
  localparam int unsigned BIT_HOST_NEG_ENABLE = 10;
  localparam int unsigned BIT_DEV_NEG_ENABLE = 11;
  localparam int unsigned BIT_CONNECTOR_ID = 16;
  localparam int unsigned BIT_DEBOUNCE_LEN = 17;
  localparam int unsigned BIT_A_SESSION_VALID = 18;
  localparam int unsigned BIT_B_SESSION_VALID = 19;

  // Event flag positions
  localparam int unsigned FLG_SESSION_END = 2;
  localparam int unsigned FLG_SESSION_OK_CHG = 8;
  localparam int unsigned FLG_NEGOTIATION_OK_CHG = 9;
  localparam int unsigned FLG_NEGOTIATION_SEEN = 17;
  localparam int unsigned FLG_A_TIMEOUT = 18;
  localparam int unsigned FLG_DEBOUNCE_DONE = 19;

  // Reset values and implemented-bit masks
  localparam logic [31:0] CTRL_RESET = 32'h0000_0800;
  localparam logic [31:0] CTRL_READ_MASK = 32'h000F_0F03;
  localparam logic [31:0] FLAG_MASK = 32'h000E_0304;
  localparam logic [31:0] FLAG_RESET = 32'h0000_0000;
  localparam logic [31:0] STORE_RESET = 32'h0000_0000;

  // Register port request
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } otgsc_bus_t;

  // Transceiver level status
  typedef struct packed {
    logic b_valid;
    logic a_valid;
    logic debounce_short;
    logic connector_b;
  } otgsc_line_t;

  // Protocol engine event pulses
  typedef struct packed {
    logic srp_done;
    logic srp_ok;
    logic hnp_done;
    logic hnp_ok;
    logic hnp_seen;
    logic a_timeout;
    logic debounce_done;
  } otgsc_evt_t;

endpackage : otgsc_pkg

/* sim/otgsc_peer.sv */
`timescale 1ns/100ps
// Far-side protocol engine and transceiver: answers each new request after a delay
module otgsc_peer
  import otgsc_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RST_B_I,
  // Requests from the block
  input wire logic SESSION_REQUEST_I,
  input wire logic NEGOTIATION_REQUEST_I,
  // Bench controls
  input wire logic OK_I,
  input wire logic SLOW_I,
  input wire otgsc_line_t LINE_I,
  input wire logic [2:0] MISC_I,
  // Towards the block
  output otgsc_line_t LINE_O,
  output otgsc_evt_t EVT_O
);
  logic session_request_d_ff;
  logic nreq_d_ff;
  logic [5:0] cnt_s_ff;
  logic [5:0] cnt_n_ff;
  logic [5:0] load;

  ////////////////////////////////////////////////////////////////
  // Answer delay; a request raised while one is pending is not answered twice
  assign load = SLOW_I ? 6'h14 : 6'h03;

  // Start a countdown on each rising request edge
  always_ff @(posedge CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      session_request_d_ff <= 1'b0;
      nreq_d_ff <= 1'b0;
      cnt_s_ff <= '0;
      cnt_n_ff <= '0;
    end else begin
      session_request_d_ff <= SESSION_REQUEST_I;
      nreq_d_ff <= NEGOTIATION_REQUEST_I;
      if (SESSION_REQUEST_I && !session_request_d_ff) cnt_s_ff <= load;
      else if (cnt_s_ff != 6'h00) cnt_s_ff <= cnt_s_ff - 6'h01;
      if (NEGOTIATION_REQUEST_I && !nreq_d_ff) cnt_n_ff <= load;
      else if (cnt_n_ff != 6'h00) cnt_n_ff <= cnt_n_ff - 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////
  // One-cycle result pulses with outcome qualifiers, levels passed through
  assign EVT_O = {cnt_s_ff == 6'h01, OK_I, cnt_n_ff == 6'h01, OK_I, MISC_I};
  assign LINE_O = LINE_I;
endmodule : otgsc_peer

/* sim/otgsc_top_tb.sv */
`timescale 1ns/100ps
module otgsc_top_tb;
  import otgsc_pkg::*;
  localparam logic [31:0] ID_VAL = 32'h0000_3C7E; // Arbitrary identity value
  logic clk, rst_b, ok, slow, session_request, nreq, hen, den, irq;
  logic [2:0] misc;
  logic [31:0] rdata;
  otgsc_bus_t bus;
  otgsc_line_t line, line_w;
  otgsc_evt_t evt;
  int n_fail = 0;
  int checks = 0;
  logic [11:0] stores [12] = '{OFS_BUS_SIDE_CFG, OFS_USB_SIDE_CFG, OFS_RESET_CONTROL,
    OFS_CORE_INT_STATUS, OFS_CORE_INT_MASK, OFS_RX_FIFO_SIZE, OFS_TX_FIFO_CFG,
    OFS_GENERAL_CFG, OFS_HOST_PER_FIFO, OFS_IN_EP_FIFO_1, OFS_IN_EP_FIFO_2, OFS_IN_EP_FIFO_3};

  ////////////////////////////////////////////////////////////////
  // Block and far side
  otgsc_top #(.CORE_ID(ID_VAL)) uut (.CLK_I(clk), .RST_B_I(rst_b), .BUS_I(bus),
    .RDATA_O(rdata), .LINE_I(line_w), .EVT_I(evt), .SESSION_REQUEST_O(session_request),
    .NEGOTIATION_REQUEST_O(nreq), .HOST_NEG_ENABLE_O(hen), .DEV_NEG_ENABLE_O(den),
    .IRQ_O(irq));
  otgsc_peer peer (.CLK_I(clk), .RST_B_I(rst_b), .SESSION_REQUEST_I(session_request),
    .NEGOTIATION_REQUEST_I(nreq), .OK_I(ok), .SLOW_I(slow), .LINE_I(line),
    .MISC_I(misc), .LINE_O(line_w), .EVT_O(evt));

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////
  // Compare, bus and closing tasks
  task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk32

  task automatic chk1(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %b seen %b", what, exp, got);
    end
  endtask : chk1

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
    @(posedge clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge clk);
    bus.rd <= 1'b0;
    #1;
    chk32(what, exp, rdata);
  endtask : rd

  // Bounded wait, the far side may answer slowly
  task automatic wait_irq();
    int i;
    for (i = 0; i < 60 && irq !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk1("irq", 1'b1, irq);
  endtask : wait_irq

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : print_verdict

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100us;
    n_fail++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    bus = '0;
    line = '0;
    misc = '0;
    ok = 1'b1;
    slow = 1'b0;
    rst_b = 1'b0;
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    rd("ctrl_reset", OFS_CONTROL_STATE, CTRL_RESET);
    rd("flags_reset", OFS_EVENT_FLAGS, FLAG_RESET);
    chk1("dev_en_reset", 1'b1, den);
    $display("test reset done");
    // Reserved and read-only bits ignore writes
    wr(OFS_CONTROL_STATE, 32'hFFFF_F1FD);
    rd("ctrl_ro", OFS_CONTROL_STATE, 32'h0000_0000);
    wr(OFS_CONTROL_STATE, 32'h0000_0C00);
    #1 chk1("host_en", 1'b1, hen);
    chk1("dev_en", 1'b1, den);
    $display("test access done");
    // Line levels, one at a time
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      line <= otgsc_line_t'(4'b0001 << k);
      rd("ctrl_line", OFS_CONTROL_STATE, 32'h0000_0C00 | (32'h1 << (16 + k)));
    end
    // Session end and engine events, all unmasked
    wr(OFS_EVENT_MASK, FLAG_MASK);
    @(posedge clk);
    line <= '0;
    misc <= 3'b111;
    @(posedge clk);
    misc <= 3'b000;
    wait_irq();
    rd("flags_misc", OFS_EVENT_FLAGS, 32'h000E_0004);
    wr(OFS_EVENT_FLAGS, 32'h000E_0004);
    rd("flags_w1c", OFS_EVENT_FLAGS, 32'h0000_0000);
    chk1("irq_clr", 1'b0, irq);
    $display("test events done");
    // Let the bus supply discharge before a new session request
    repeat (50) @(posedge clk);
    wr(OFS_CONTROL_STATE, 32'h0000_0C02);
    #1 chk1("session_request_o", 1'b1, session_request);
    wait_irq();
    rd("ctrl_srp", OFS_CONTROL_STATE, 32'h0000_0C03);
    rd("flags_srp", OFS_EVENT_FLAGS, 32'h0000_0100);
    wr(OFS_EVENT_FLAGS, 32'h0000_0100);
    wr(OFS_CONTROL_STATE, 32'h0000_0C00);
    #1 chk1("session_request_sw_clr", 1'b0, session_request);
    $display("test session done");
    // Slow successful negotiation; clearing the change flag drops both requests
    slow <= 1'b1;
    wr(OFS_CONTROL_STATE, 32'h0000_0E02);
    #1 chk1("nreq_o", 1'b1, nreq);
    wait_irq();
    rd("ctrl_hnp", OFS_CONTROL_STATE, 32'h0000_0F03);
    rd("flags_hnp", OFS_EVENT_FLAGS, 32'h0000_0200);
    wr(OFS_EVENT_FLAGS, 32'h0000_0200);
    rd("ctrl_auto", OFS_CONTROL_STATE, 32'h0000_0D01);
    chk1("nreq_auto", 1'b0, nreq);
    chk1("session_request_auto", 1'b0, session_request);
    chk1("irq_drop", 1'b0, irq);
    $display("test negotiation done");
    // New request clears the outcome; failure answer, flag masked
    ok <= 1'b0;
    slow <= 1'b0;
    wr(OFS_EVENT_MASK, 32'h0000_0000);
    wr(OFS_CONTROL_STATE, 32'h0000_0E02);
    rd("ctrl_clr", OFS_CONTROL_STATE, 32'h0000_0E03);
    repeat (30) @(posedge clk);
    #1 chk1("irq_masked", 1'b0, irq);
    rd("flags_fail", OFS_EVENT_FLAGS, 32'h0000_0300);
    wr(OFS_EVENT_FLAGS, 32'h0000_0300);
    rd("ctrl_fail", OFS_CONTROL_STATE, 32'h0000_0C00);
    $display("test failure done");
    // Address map
    for (int j = 0; j < 12; j++) begin
      wr(stores[j], 32'hA5C3_0000 | 32'(j));
      rd("store", stores[j], 32'hA5C3_0000 | 32'(j));
    end
    rd("identity", OFS_CORE_IDENTITY, ID_VAL);
    @(posedge clk);
    #1 chk32("rdata_idle", 32'h0000_0000, rdata);
    wr(12'h034, 32'hFFFF_FFFF);
    rd("unmapped", 12'h034, 32'h0000_0000);
    rd("unmapped_hi", 12'h200, 32'h0000_0000);
    wr(OFS_RX_STATUS_POP, 32'hFFFF_FFFF);
    rd("queue_ro", OFS_RX_STATUS_POP, 32'h0000_0000);
    $display("test map done");
    print_verdict();
  end
endmodule : otgsc_top_tb
